// ### smoke_seq_pkg.sv
package smoke_seq_pkg;
  // ****************************************************************
  // clock and internal oscillator
  // ****************************************************************
  localparam int MCLK_PERIOD_NS = 40;
  localparam int OSC_LOW_NS = 10_400_000;
  localparam int OSC_HIGH_NS = 105_000;
  localparam int OSC_LOW_CYCLES = OSC_LOW_NS / MCLK_PERIOD_NS;
  localparam int OSC_HIGH_CYCLES = OSC_HIGH_NS / MCLK_PERIOD_NS;
  localparam int OSC_PERIOD_US = (OSC_LOW_NS + OSC_HIGH_NS) / 1000;
  localparam int MCLK_CNT_W = 18;
  // ****************************************************************
  // intervals in oscillator periods
  // ****************************************************************
  localparam int LAMP_STANDBY_MS = 43_000;
  localparam int LAMP_FAST_MS = 500;
  localparam int LAMP_TIMER_MS = 10_000;
  localparam int EMIT_STANDBY_MS = 10_000;
  localparam int EMIT_ONE_MS = 2_000;
  localparam int EMIT_TWO_MS = 1_000;
  localparam int EMIT_REMOTE_MS = 8_000;
  localparam int EMIT_TEST_MS = 252;
  localparam int DUMP_MS = 1_000;
  localparam int HORN_ON_MS = 500;
  localparam int HORN_LONG_OFF_MS = 1_500;
  localparam int HUSH_MS = 600_000;
  localparam int OSC_TICKS_LAMP_STANDBY = LAMP_STANDBY_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_LAMP_FAST = LAMP_FAST_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_LAMP_TIMER = LAMP_TIMER_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_EMIT_STANDBY = EMIT_STANDBY_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_EMIT_ONE = EMIT_ONE_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_EMIT_TWO = EMIT_TWO_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_EMIT_REMOTE = EMIT_REMOTE_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_EMIT_TEST = EMIT_TEST_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_DUMP = DUMP_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_HORN_ON = HORN_ON_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_HORN_LONG = HORN_LONG_OFF_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_HUSH = HUSH_MS * 1000 / OSC_PERIOD_US;
  localparam int OSC_TICKS_HORN_CYCLE = 5 * OSC_TICKS_HORN_ON + OSC_TICKS_HORN_LONG;
  // ****************************************************************
  // interconnect qualification and smoke integration
  // ****************************************************************
  localparam logic [1:0] IO_SAMPLE_PHASE = 2'h3;
  localparam logic [1:0] IO_SAMPLES_NEEDED = 2'h3;
  localparam logic [1:0] SMOKE_HITS_NEEDED = 2'h3;
  // ****************************************************************
  // supervisory schedule within the standby lamp period
  // ****************************************************************
  localparam logic [11:0] CHAMBER_SLOT = 12'h0400;
  localparam logic [11:0] BATT_SLOT = 12'h0800;
endpackage

// ### smoke_seq.sv
// Overview of operation
// R1 - emitter off while horn or lamp on
// R2 - local smoke drives interconnect line high
// R3 - sample interconnect every fourth oscillator period
// R4 - three high samples plus one period alarm
// R5 - interconnect low during window clears qualification
// R6 - remote unit holds line 95 to 137 ms
// R7 - remote-only alarm suppresses lamp pulses
// R8 - local alarm ignores interconnect input
// R9 - alarm end turns on interconnect discharge
// R10 - discharge stays on about one second
// R11 - battery check never overlaps tests or alarms; code checks them before the slot tick, so one starting on that tick overlaps
// R12 - lamp period 43 s, 0.5 s, none, 10 s
// R13 - high gain in test and chamber check
// R14 - low gain in standby
// R15 - confirmed local alarm boosts low gain
// R16 - oscillator low phase about 10.4 ms
// R17 - emitter pulse equals 105 us high phase
// R18 - quiet enabled: button release starts hush
// R19 - quiet disabled: hush timer never starts
// R20 - hush lasts ten minutes from last start
// R21 - hush uses external reference, else internal
// R22 - horn temporal pattern three bursts, long off
// R23 - oscillator-counted intervals, reset to standby
module smoke_seq #(
  parameter int OSC_LOW_COUNT = smoke_seq_pkg::OSC_LOW_CYCLES,
  parameter int OSC_HIGH_COUNT = smoke_seq_pkg::OSC_HIGH_CYCLES,
  parameter int HUSH_COUNT = smoke_seq_pkg::OSC_TICKS_HUSH
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_smoke_detect,
  input wire logic i_io_level,
  input wire logic i_test_button,
  input wire logic i_quiet_enable,
  output logic o_emitter_pulse,
  output logic o_io_drive,
  output logic o_io_drive_en_n,
  output logic o_io_discharge,
  output logic o_piezo_drive_a,
  output logic o_piezo_drive_b,
  output logic o_lamp,
  output logic o_high_gain_cap,
  output logic o_low_gain_cap,
  output logic o_gain_boost,
  output logic o_external_reference,
  output logic o_battery_load,
  output logic o_remote_alarm,
  output logic o_local_alarm,
  output logic o_hush_mode
);
  import smoke_seq_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [MCLK_CNT_W-1:0] mclk_cnt;
    logic osc_high;
    logic [1:0] osc_div;
    logic [9:0] emit_cnt;
    logic [1:0] smoke_hits;
    logic local_alarm;
    logic test_mode;
    logic [1:0] test_hits;
    logic test_alarm;
    logic button_d;
    logic [1:0] qual_cnt;
    logic qual_wait;
    logic remote_alarm;
    logic alarm_d;
    logic [6:0] dump_cnt;
    logic [15:0] hush_cnt;
    logic hush;
    logic [8:0] horn_cnt;
    logic [11:0] lamp_cnt;
    logic [11:0] super_cnt;
    logic emitter;
    logic io_drive;
    logic io_dump;
    logic horn;
    logic lamp;
    logic high_gain;
    logic batt;
  } seq_state_type;

  seq_state_type s;
  seq_state_type next_s;

  function automatic logic horn_phase_on(input logic [8:0] cnt);
    horn_phase_on = (cnt < 9'(OSC_TICKS_HORN_ON)) ||
                    (cnt >= 9'(2 * OSC_TICKS_HORN_ON) && cnt < 9'(3 * OSC_TICKS_HORN_ON)) ||
                    (cnt >= 9'(4 * OSC_TICKS_HORN_ON) && cnt < 9'(5 * OSC_TICKS_HORN_ON));
  endfunction

  logic osc_rise;
  logic osc_tick;
  logic any_alarm;
  logic chamber_slot;
  logic [11:0] lamp_period;
  logic [9:0] emit_period;

  // ****************************************************************
  // oscillator phases and mode selects
  // ****************************************************************
  assign osc_rise = !s.osc_high && s.mclk_cnt == MCLK_CNT_W'(OSC_LOW_COUNT - 1); // R16
  assign osc_tick = s.osc_high && s.mclk_cnt == MCLK_CNT_W'(OSC_HIGH_COUNT - 1); // R17
  assign any_alarm = s.local_alarm || s.remote_alarm || s.test_alarm;
  assign chamber_slot = s.super_cnt == CHAMBER_SLOT && !any_alarm && !s.test_mode && !s.hush;

  always_comb begin
    if (s.local_alarm || s.test_mode) begin
      lamp_period = 12'(OSC_TICKS_LAMP_FAST); // R12
    end else if (s.hush) begin
      lamp_period = 12'(OSC_TICKS_LAMP_TIMER); // R12
    end else begin
      lamp_period = 12'(OSC_TICKS_LAMP_STANDBY); // R12
    end
    if (s.test_mode) begin
      emit_period = 10'(OSC_TICKS_EMIT_TEST);
    end else if (s.local_alarm || s.smoke_hits == 2'h2) begin
      emit_period = 10'(OSC_TICKS_EMIT_TWO);
    end else if (s.smoke_hits == 2'h1) begin
      emit_period = 10'(OSC_TICKS_EMIT_ONE);
    end else if (s.remote_alarm) begin
      emit_period = 10'(OSC_TICKS_EMIT_REMOTE);
    end else begin
      emit_period = 10'(OSC_TICKS_EMIT_STANDBY);
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.mclk_cnt = s.mclk_cnt + MCLK_CNT_W'(1);
    if (osc_rise) begin
      next_s.mclk_cnt = '0;
      next_s.osc_high = 1'b1;
      if (s.emit_cnt == 10'h000 || chamber_slot) begin
        next_s.emitter = !s.horn && !s.lamp; // R1 R17
        if (!s.horn && !s.lamp) begin
          next_s.emit_cnt = emit_period;
        end
      end
    end
    if (osc_tick) begin
      next_s.mclk_cnt = '0;
      next_s.osc_high = 1'b0;
      next_s.emitter = 1'b0;
      next_s.osc_div = s.osc_div + 2'h1;
      if (s.emit_cnt != 10'h000) begin
        next_s.emit_cnt = s.emit_cnt - 10'h001;
      end
      // smoke integration on each low-gain or test-mode emitter pulse
      if (s.emitter && s.test_mode) begin
        if (i_smoke_detect) begin
          next_s.test_hits = (s.test_hits == SMOKE_HITS_NEEDED) ? s.test_hits : s.test_hits + 2'h1;
          next_s.test_alarm = s.test_hits >= SMOKE_HITS_NEEDED - 2'h1;
        end else begin
          next_s.test_hits = 2'h0;
          next_s.test_alarm = 1'b0;
        end
      end else if (s.emitter && !s.high_gain) begin
        if (i_smoke_detect) begin
          next_s.smoke_hits = (s.smoke_hits == SMOKE_HITS_NEEDED) ? s.smoke_hits : s.smoke_hits + 2'h1;
          if (s.smoke_hits >= SMOKE_HITS_NEEDED - 2'h1) begin
            next_s.local_alarm = 1'b1;
          end
        end else begin
          next_s.smoke_hits = 2'h0;
          next_s.local_alarm = 1'b0;
        end
      end
      // push-to-test follows the button one period later
      next_s.button_d = i_test_button;
      next_s.test_mode = i_test_button;
      if (!i_test_button) begin
        next_s.test_hits = 2'h0;
        next_s.test_alarm = 1'b0;
      end
      // hush timer
      if (s.button_d && !i_test_button && i_quiet_enable) begin
        next_s.hush = 1'b1; // R18
        next_s.hush_cnt = 16'(HUSH_COUNT - 1); // R20
      end else if (!i_quiet_enable) begin
        next_s.hush = 1'b0; // R19
        next_s.hush_cnt = 16'h0000;
      end else if (s.hush_cnt != 16'h0000) begin
        next_s.hush_cnt = s.hush_cnt - 16'h0001; // R20 R23
      end else begin
        next_s.hush = 1'b0; // R20
      end
      // interconnect qualification
      if (s.local_alarm || s.test_alarm) begin
        next_s.qual_cnt = 2'h0; // R8
        next_s.qual_wait = 1'b0;
        next_s.remote_alarm = 1'b0;
      end else if (s.qual_wait) begin
        next_s.qual_wait = 1'b0;
        next_s.remote_alarm = 1'b1; // R4
      end else if (s.osc_div == IO_SAMPLE_PHASE) begin
        if (i_io_level) begin
          if (!s.remote_alarm) begin
            next_s.qual_cnt = s.qual_cnt + 2'h1; // R3
            next_s.qual_wait = s.qual_cnt == IO_SAMPLES_NEEDED - 2'h1; // R4
          end
        end else begin
          next_s.qual_cnt = 2'h0;
          next_s.remote_alarm = 1'b0;
        end
      end
      // interconnect discharge after a local or test alarm
      next_s.alarm_d = s.local_alarm || s.test_alarm;
      if (s.alarm_d && !(s.local_alarm || s.test_alarm)) begin
        next_s.dump_cnt = 7'(OSC_TICKS_DUMP); // R9 R10
      end else if (s.dump_cnt != 7'h00) begin
        next_s.dump_cnt = s.dump_cnt - 7'h01; // R10
      end
      // temporal horn pattern
      if (any_alarm) begin
        next_s.horn = horn_phase_on(s.horn_cnt); // R22
        next_s.horn_cnt = (s.horn_cnt == 9'(OSC_TICKS_HORN_CYCLE - 1)) ? 9'h000 : s.horn_cnt + 9'h001;
      end else begin
        next_s.horn = 1'b0;
        next_s.horn_cnt = 9'h000;
      end
      // status lamp, one oscillator period wide
      next_s.lamp = 1'b0;
      if (s.lamp_cnt >= lamp_period - 12'h001) begin
        next_s.lamp_cnt = 12'h000;
        next_s.lamp = !(s.remote_alarm && !s.local_alarm && !s.test_mode); // R7 R12
      end else begin
        next_s.lamp_cnt = s.lamp_cnt + 12'h001;
      end
      // supervisory schedule: chamber check and battery load in separate slots
      next_s.super_cnt = (s.super_cnt == 12'(OSC_TICKS_LAMP_STANDBY - 1)) ? 12'h000 : s.super_cnt + 12'h001;
      next_s.batt = next_s.super_cnt == BATT_SLOT && !any_alarm && !s.test_mode &&
                    !next_s.lamp && !next_s.horn && next_s.dump_cnt == 7'h00; // R11
    end
    // qualification latch dropped the moment the line falls
    if (!i_io_level && (s.qual_cnt != 2'h0 || s.qual_wait) && !s.remote_alarm) begin
      next_s.qual_cnt = 2'h0; // R5
      next_s.qual_wait = 1'b0; // R5
    end
    next_s.high_gain = next_s.test_mode || (next_s.super_cnt == CHAMBER_SLOT &&
                       !any_alarm && !next_s.test_mode && !s.hush); // R13 R14
    next_s.io_drive = next_s.local_alarm || next_s.test_alarm; // R2
    next_s.io_dump = next_s.dump_cnt != 7'h00 && !next_s.io_drive; // R9
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      s <= '0; // R23
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_emitter_pulse <= 1'b0;
      o_io_drive <= 1'b0;
      o_io_drive_en_n <= 1'b1;
      o_io_discharge <= 1'b0;
      o_piezo_drive_a <= 1'b0;
      o_piezo_drive_b <= 1'b0;
      o_lamp <= 1'b0;
      o_high_gain_cap <= 1'b0;
      o_low_gain_cap <= 1'b1;
      o_gain_boost <= 1'b0;
      o_external_reference <= 1'b0;
      o_battery_load <= 1'b0;
      o_remote_alarm <= 1'b0;
      o_local_alarm <= 1'b0;
      o_hush_mode <= 1'b0;
    end else begin
      o_emitter_pulse <= next_s.emitter; // R1 R17
      o_io_drive <= next_s.io_drive; // R2
      o_io_drive_en_n <= !next_s.io_drive;
      o_io_discharge <= next_s.io_dump;
      o_piezo_drive_a <= next_s.horn;
      o_piezo_drive_b <= next_s.horn;
      o_lamp <= next_s.lamp;
      o_high_gain_cap <= next_s.high_gain; // R13
      o_low_gain_cap <= !next_s.high_gain; // R14
      o_gain_boost <= next_s.local_alarm && !next_s.high_gain; // R15
      o_external_reference <= next_s.hush; // R21
      o_battery_load <= next_s.batt; // R11
      o_remote_alarm <= next_s.remote_alarm;
      o_local_alarm <= next_s.local_alarm;
      o_hush_mode <= next_s.hush;
    end
  end

endmodule // smoke_seq

// ### smoke_seq_props.sv
// ****************************************************************
// port checker for the alarm sequencer
// ****************************************************************
module smoke_seq_props
  import smoke_seq_pkg::*;
#(
  parameter int OSC_LOW_COUNT = 20,
  parameter int OSC_HIGH_COUNT = 5
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_io_level,
  input wire logic i_quiet_enable,
  input wire logic o_emitter_pulse,
  input wire logic o_io_drive,
  input wire logic o_io_drive_en_n,
  input wire logic o_io_discharge,
  input wire logic o_piezo_drive_a,
  input wire logic o_piezo_drive_b,
  input wire logic o_lamp,
  input wire logic o_high_gain_cap,
  input wire logic o_low_gain_cap,
  input wire logic o_gain_boost,
  input wire logic o_external_reference,
  input wire logic o_battery_load,
  input wire logic o_remote_alarm,
  input wire logic o_local_alarm,
  input wire logic o_hush_mode
);
  localparam int PER = OSC_LOW_COUNT + OSC_HIGH_COUNT;
  int high_run;
  int emit_run;
  int dump_run;
  // runs of consecutive high cycles, used to judge widths and filters
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      high_run <= 0;
      emit_run <= 0;
      dump_run <= 0;
    end else begin
      high_run <= i_io_level ? high_run + 1 : 0;
      emit_run <= o_emitter_pulse ? emit_run + 1 : 0;
      dump_run <= o_io_discharge ? dump_run + 1 : 0;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  emit_quiet_a: assert property (o_emitter_pulse |-> !(o_piezo_drive_a || o_piezo_drive_b || o_lamp))
    else $error("emitter on with horn or lamp");
  io_drive_local_a: assert property ($rose(o_local_alarm) |=> o_io_drive && !o_io_drive_en_n)
    else $error("line not driven on local alarm");
  remote_filter_a: assert property ($rose(o_remote_alarm) |-> high_run >= 8 * PER)
    else $error("remote alarm on short high level");
  lamp_remote_a: assert property ($rose(o_lamp) |-> !(o_remote_alarm && !o_local_alarm))
    else $error("lamp pulse during remote alarm");
  local_ignore_a: assert property (o_local_alarm |=> !$rose(o_remote_alarm))
    else $error("remote taken during local alarm");
  dump_after_a: assert property ($rose(o_io_discharge) |-> !o_local_alarm)
    else $error("discharge during local alarm");
  dump_length_a: assert property ($fell(o_io_discharge) |-> dump_run >= 94 * PER && dump_run <= 96 * PER)
    else $error("discharge length wrong");
  battery_alone_a: assert property (o_battery_load |-> !(o_lamp || o_piezo_drive_a || o_io_discharge
    || o_local_alarm || o_remote_alarm || o_high_gain_cap))
    else $error("battery test overlaps activity");
  gain_select_a: assert property (o_high_gain_cap != o_low_gain_cap)
    else $error("gain selects not complementary");
  boost_local_a: assert property (o_gain_boost |-> o_local_alarm && o_low_gain_cap)
    else $error("gain boost outside local alarm");
  emit_width_a: assert property ($fell(o_emitter_pulse) |-> emit_run == OSC_HIGH_COUNT)
    else $error("emitter pulse width wrong");
  quiet_cancel_a: assert property (!i_quiet_enable && !o_hush_mode |=> !o_hush_mode)
    else $error("hush with quiet input low");
  hush_ref_a: assert property ($rose(o_hush_mode) |-> ##[0:1] o_external_reference)
    else $error("hush without external reference");
endmodule // smoke_seq_props

bind smoke_seq smoke_seq_props #(.OSC_LOW_COUNT(OSC_LOW_COUNT), .OSC_HIGH_COUNT(OSC_HIGH_COUNT))
  smoke_seq_props_inst (.*);

// ### smoke_io_peer.sv
// ****************************************************************
// another alarm unit on the shared interconnect line
// ****************************************************************
module smoke_io_peer (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [31:0] i_hold,
  input wire logic i_dev_drive,
  input wire logic i_dev_en_n,
  output logic o_line
);
  logic [31:0] cnt = 32'h0000_0000;
  // holds the line high for the commanded number of cycles
  always_ff @(posedge i_mclk) begin
    if (i_go) begin
      cnt <= i_hold;
    end else if (cnt != 32'h0000_0000) begin
      cnt <= cnt - 32'h0000_0001;
    end
  end
  // the pull-down leaves a released line low
  assign o_line = (cnt != 32'h0000_0000) | (!i_dev_en_n & i_dev_drive);
endmodule // smoke_io_peer

// ### tb_smoke_seq.sv
module tb_smoke_seq;
  timeunit 1ns;
  timeprecision 1ns;
  import smoke_seq_pkg::*;
  localparam int HIGH_SIM = 5;
  localparam int PER = 20 + HIGH_SIM;
  logic i_mclk = 0, i_reset = 1, i_test_button = 0, i_quiet_enable = 0, go = 0, rem_seen = 0, smoke = 0;
  logic [31:0] hold = 32'h0000_0000;
  wire logic io_line;
  logic o_emitter_pulse, o_io_drive, o_io_drive_en_n, o_io_discharge, o_piezo_drive_a, o_piezo_drive_b;
  logic o_lamp, o_high_gain_cap, o_low_gain_cap, o_gain_boost, o_external_reference, o_battery_load;
  logic o_remote_alarm, o_local_alarm, o_hush_mode;
  int n_fail = 0, checks_done = 0;
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (o_remote_alarm === 1'b1) rem_seen <= 1'b1;
  smoke_seq #(.OSC_LOW_COUNT(20), .OSC_HIGH_COUNT(HIGH_SIM), .HUSH_COUNT(30)) smoke_seq_inst (.i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_smoke_detect(smoke), .i_io_level(io_line), .i_test_button(i_test_button), .i_quiet_enable(i_quiet_enable),
    .o_emitter_pulse(o_emitter_pulse), .o_io_drive(o_io_drive), .o_io_drive_en_n(o_io_drive_en_n),
    .o_io_discharge(o_io_discharge), .o_piezo_drive_a(o_piezo_drive_a), .o_piezo_drive_b(o_piezo_drive_b),
    .o_lamp(o_lamp), .o_high_gain_cap(o_high_gain_cap), .o_low_gain_cap(o_low_gain_cap),
    .o_gain_boost(o_gain_boost), .o_external_reference(o_external_reference), .o_battery_load(o_battery_load),
    .o_remote_alarm(o_remote_alarm), .o_local_alarm(o_local_alarm), .o_hush_mode(o_hush_mode));
  smoke_io_peer smoke_io_peer_inst (.i_mclk(i_mclk), .i_go(go), .i_hold(hold), .i_dev_drive(o_io_drive),
    .i_dev_en_n(o_io_drive_en_n), .o_line(io_line));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic cmp(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic osc(input int n);
    repeat (n * PER) @(posedge i_mclk);
    #2;
  endtask
  task automatic peer_hold(input int n);
    go = 1;
    hold = 32'(n);
    @(posedge i_mclk);
    #2 go = 0;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check_reset;
    cmp("io_drive_en_n", 1, o_io_drive_en_n);
    cmp("low_gain_cap", 1, o_low_gain_cap);
    cmp("remote_alarm", 0, o_remote_alarm);
    cmp("hush_mode", 0, o_hush_mode);
  endtask
  task automatic remote_glitch;
    rem_seen = 0;
    peer_hold(5 * PER);
    osc(5);
    peer_hold(5 * PER);
    osc(7);
    cmp("short high ignored", 0, rem_seen);
  endtask
  task automatic remote_alarm;
    int t;
    t = 0;
    peer_hold(13 * PER);
    while (o_remote_alarm !== 1'b1 && t < 13 * PER) begin
      @(posedge i_mclk);
      t++;
    end
    #2;
    cmp("remote_alarm", 1, o_remote_alarm);
    cmp("remote not early", 1, t >= 8 * PER);
    cmp("line not driven", 1, o_io_drive_en_n);
    osc(1);
    cmp("lamp", 0, o_lamp);
    osc(9);
    cmp("remote cleared", 0, o_remote_alarm);
    cmp("no discharge", 0, o_io_discharge);
  endtask
  task automatic hush_start;
    i_quiet_enable = 1;
    i_test_button = 1;
    osc(3);
    cmp("high_gain_cap", 1, o_high_gain_cap);
    i_test_button = 0;
    osc(3);
    cmp("hush_mode", 1, o_hush_mode);
    cmp("external_reference", 1, o_external_reference);
    cmp("low_gain_cap", 1, o_low_gain_cap);
    i_quiet_enable = 0;
    osc(1);
    cmp("hush cancelled", 0, o_hush_mode);
    cmp("internal reference", 0, o_external_reference);
  endtask
  task automatic hush_disabled;
    i_test_button = 1;
    osc(2);
    i_test_button = 0;
    osc(3);
    cmp("hush blocked", 0, o_hush_mode);
  endtask
  task automatic local_alarm;
    int t;
    t = 0;
    smoke = 1;
    while (o_local_alarm !== 1'b1 && t < 1400 * PER) begin
      @(posedge i_mclk);
      t++;
    end
    #2;
    cmp("local_alarm", 1, o_local_alarm);
    cmp("io_drive", 1, o_io_drive);
    cmp("io_drive_en_n", 0, o_io_drive_en_n);
    cmp("gain_boost", 1, o_gain_boost);
    cmp("remote ignored", 0, o_remote_alarm);
    smoke = 0;
    t = 0;
    while (o_local_alarm !== 1'b0 && t < 300 * PER) begin
      @(posedge i_mclk);
      t++;
    end
    osc(2);
    cmp("io_discharge", 1, o_io_discharge);
    cmp("line released", 1, o_io_drive_en_n);
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (3) @(posedge i_mclk);
    #2 i_reset = 0;
    @(posedge i_mclk);
    #2;
    check_reset();
    remote_glitch();
    remote_alarm();
    hush_start();
    hush_disabled();
    local_alarm();
    finish_test();
  end
  initial begin
    repeat (1800 * PER) @(posedge i_mclk);
    n_fail++;
    finish_test();
  end
endmodule // tb_smoke_seq
